// ### logic/alu_defines.svh
`ifndef ALU_DEFINES_SVH
`define ALU_DEFINES_SVH
`define OFS_CTRL 8'h00
`define OFS_DEST 8'h04
`define OFS_SRC 8'h08
`define OFS_FLAGS 8'h0C
`define OFS_IOFLAG 8'h10
`define OFS_IOGP 8'h14
`define OFS_IOBIT 8'h18
`define FLG_C 0
`define FLG_Z 1
`define FLG_N 2
`define FLG_V 3
`define FLG_S 4
`define FLG_H 5
`define CTRL_BUSY 8
`define CTRL_REFUSED 9
`define IOBIT_SET 7
`define OP_LAST 4'hB
`define IO_LAST 6'h1F
`define IO_ADDR_FLAGS 6'h0E
`define IO_ADDR_GP 6'h0F
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_FLAGS 6'h00
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2
`endif

// ### logic/alu_pkg.sv
`default_nettype none
package alu_pkg;
    typedef enum logic [3:0] {
        OP_ADD_REG = 4'h0,
        OP_ADD_CARRY = 4'h1,
        OP_SUB_REG = 4'h2,
        OP_SUB_CARRY = 4'h3,
        OP_SUB_IMM = 4'h4,
        OP_SUB_IMM_CARRY = 4'h5,
        OP_AND_REG = 4'h6,
        OP_AND_IMM = 4'h7,
        OP_OR_REG = 4'h8,
        OP_OR_IMM = 4'h9,
        OP_ADD_WORD = 4'hA,
        OP_SUB_WORD = 4'hB
    } op_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WORD_LO = 2'h1,
        ST_WORD_HI = 2'h3,
        ST_BYTE = 2'h2
    } state_type;
endpackage
`default_nettype wire

// ### logic/byte_word_arith_logic_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "alu_defines.svh"
module byte_word_arith_logic_unit
    import alu_pkg::*;
#(
    parameter int WORD_IMM_W = 6
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // i/o side
    input wire logic [7:0] IO_EVENT,
    output logic [7:0] GP_IO_OUT
);

    localparam logic [7:0] WORD_IMM_MASK = 8'((1 << WORD_IMM_W) - 1);

    // returns {half carry, overflow, carry, result}
    function automatic logic [10:0] byte_arith(input logic [7:0] a,
        input logic [7:0] b, input logic cin, input logic sub);
        logic [7:0] r;
        logic [7:0] ax;
        logic [7:0] rx;
        logic [7:0] bv;
        logic [7:0] cy;
        logic v;
        r = sub ? 8'(a - b - {7'h00, cin}) : 8'(a + b + {7'h00, cin});
        ax = sub ? ~a : a;
        rx = sub ? r : ~r;
        cy = (ax & b) | (b & rx) | (rx & ax);
        bv = sub ? ~b : b;
        v = (a[7] & bv[7] & ~r[7]) | (~a[7] & ~bv[7] & r[7]);
        return {cy[3], v, cy[7], r};
    endfunction

    state_type state;
    state_type next_state;
    op_type op_q;
    logic [15:0] dest;
    logic [15:0] next_dest;
    logic [7:0] src;
    logic [5:0] flags;
    logic [5:0] next_flags;
    logic [7:0] lo_res;
    logic [7:0] next_lo;
    logic lo_c;
    logic next_lo_c;
    logic [7:0] io_flags;
    logic [7:0] gp;
    logic io_refused;
    logic wr_pend;
    logic rd_pend;
    logic hit_q;
    logic [7:0] addr_q;

    // bus decode
    wire addr_ok = HSEL && HREADY && HTRANS == `HTRANS_NONSEQ;
    wire wr_en = wr_pend && hit_q;
    wire busy = state != ST_IDLE;
    wire ctrl_wr = wr_en && addr_q == `OFS_CTRL;
    wire dest_wr = wr_en && addr_q == `OFS_DEST && !busy;
    wire src_wr = wr_en && addr_q == `OFS_SRC && !busy;
    wire flags_wr = wr_en && addr_q == `OFS_FLAGS && !busy;
    wire ioflag_wr = wr_en && addr_q == `OFS_IOFLAG;
    wire iogp_wr = wr_en && addr_q == `OFS_IOGP;
    wire iobit_wr = wr_en && addr_q == `OFS_IOBIT;
    // a command written while busy or with a bad code is dropped
    wire start = ctrl_wr && !busy && HWDATA[3:0] <= `OP_LAST;
    wire start_word = HWDATA[3:0] == OP_ADD_WORD
        || HWDATA[3:0] == OP_SUB_WORD;

    // operation decode
    wire op_sub = op_q inside {OP_SUB_REG, OP_SUB_CARRY, OP_SUB_IMM,
        OP_SUB_IMM_CARRY, OP_SUB_WORD};
    wire op_carry = op_q inside {OP_ADD_CARRY, OP_SUB_CARRY,
        OP_SUB_IMM_CARRY};
    wire op_logic = op_q inside {OP_AND_REG, OP_AND_IMM, OP_OR_REG,
        OP_OR_IMM};
    wire op_and = op_q == OP_AND_REG || op_q == OP_AND_IMM;
    wire [7:0] logic_res = op_and ? dest[7:0] & src : dest[7:0] | src;
    wire [10:0] byte_out = byte_arith(dest[7:0], src,
        op_carry & flags[`FLG_C], op_sub);
    wire [10:0] lo_out = byte_arith(dest[7:0], src & WORD_IMM_MASK,
        1'b0, op_sub);
    wire [10:0] hi_out = byte_arith(dest[15:8], 8'h00, lo_c, op_sub);
    wire hi_v = op_sub ? dest[15] & ~hi_out[7] : ~dest[15] & hi_out[7];
    wire hi_c = op_sub ? hi_out[7] & ~dest[15] : ~hi_out[7] & dest[15];

    // i/o bit read-modify-write
    wire [5:0] io_addr = HWDATA[13:8];
    wire io_in_range = io_addr <= `IO_LAST;
    wire [7:0] io_bit_mask = 8'h01 << HWDATA[2:0];
    wire io_hit_flags = iobit_wr && io_in_range
        && io_addr == `IO_ADDR_FLAGS;
    wire io_hit_gp = iobit_wr && io_in_range && io_addr == `IO_ADDR_GP;
    wire [7:0] io_old = io_addr == `IO_ADDR_FLAGS ? io_flags
        : io_addr == `IO_ADDR_GP ? gp : 8'h00;
    wire [7:0] io_new = HWDATA[`IOBIT_SET] ? io_old | io_bit_mask
        : io_old & ~io_bit_mask;
    wire [7:0] flag_clear = ioflag_wr ? HWDATA[7:0]
        : io_hit_flags ? io_new : 8'h00;

    wire [31:0] rd_mux = !hit_q ? 32'h0000_0000
        : addr_q == `OFS_CTRL ? {22'h0, io_refused, busy, 4'h0, op_q}
        : addr_q == `OFS_DEST ? {16'h0000, dest}
        : addr_q == `OFS_SRC ? {24'h000000, src}
        : addr_q == `OFS_FLAGS ? {26'h0, flags}
        : addr_q == `OFS_IOFLAG ? {24'h000000, io_flags}
        : addr_q == `OFS_IOGP ? {24'h000000, gp}
        : 32'h0000_0000;

    always_comb
    begin
        next_state = state;
        next_dest = dest;
        next_flags = flags;
        next_lo = lo_res;
        next_lo_c = lo_c;
        case (state)
            ST_IDLE:
            begin
                if (start)
                    next_state = start_word ? ST_WORD_LO : ST_BYTE;
                if (dest_wr)
                    next_dest = HWDATA[15:0];
                if (flags_wr)
                    next_flags = HWDATA[5:0];
            end
            ST_BYTE:
            begin
                next_state = ST_IDLE;
                if (op_logic)
                begin
                    next_dest[7:0] = logic_res;
                    next_flags[`FLG_Z] = logic_res == 8'h00;
                    next_flags[`FLG_N] = logic_res[7];
                    next_flags[`FLG_V] = 1'b0;
                end
                else
                begin
                    next_dest[7:0] = byte_out[7:0];
                    next_flags[`FLG_C] = byte_out[8];
                    next_flags[`FLG_V] = byte_out[9];
                    next_flags[`FLG_H] = byte_out[10];
                    next_flags[`FLG_Z] = byte_out[7:0] == 8'h00;
                    next_flags[`FLG_N] = byte_out[7];
                end
            end
            ST_WORD_LO:
            begin
                next_state = ST_WORD_HI;
                next_lo = lo_out[7:0];
                next_lo_c = lo_out[8];
            end
            ST_WORD_HI:
            begin
                next_state = ST_IDLE;
                next_dest = {hi_out[7:0], lo_res};
                next_flags[`FLG_C] = hi_c;
                next_flags[`FLG_V] = hi_v;
                next_flags[`FLG_N] = hi_out[7];
                next_flags[`FLG_Z] = {hi_out[7:0], lo_res} == 16'h0000;
                next_flags[`FLG_S] = hi_out[7] ^ hi_v;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state <= ST_IDLE;
            op_q <= OP_ADD_REG;
            dest <= `RST_WORD;
            src <= `RST_BYTE;
            flags <= `RST_FLAGS;
            lo_res <= `RST_BYTE;
            lo_c <= 1'b0;
        end
        else
        begin
            state <= next_state;
            dest <= next_dest;
            flags <= next_flags;
            lo_res <= next_lo;
            lo_c <= next_lo_c;
            if (start)
                op_q <= op_type'(HWDATA[3:0]);
            if (src_wr)
                src <= HWDATA[7:0];
        end
    end

    // set wins over clear so an event in the clearing cycle survives
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            io_flags <= `RST_BYTE;
            gp <= `RST_BYTE;
            io_refused <= 1'b0;
        end
        else
        begin
            io_flags <= (io_flags & ~flag_clear) | IO_EVENT;
            if (iogp_wr)
                gp <= HWDATA[7:0];
            else if (io_hit_gp)
                gp <= io_new;
            if (iobit_wr)
                io_refused <= !io_in_range;
        end
    end

    // reads take one wait state so a write just before is seen
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            hit_q <= 1'b0;
            addr_q <= 8'h00;
            HRDATA <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
        else
        begin
            HRESP <= 1'b0;
            wr_pend <= addr_ok && HWRITE;
            rd_pend <= addr_ok && !HWRITE;
            if (addr_ok)
            begin
                addr_q <= HADDR[7:0];
                hit_q <= HADDR[31:8] == 24'h000000 && HSIZE == `HSIZE_WORD;
            end
            if (addr_ok && !HWRITE)
                HREADYOUT <= 1'b0;
            else
                HREADYOUT <= 1'b1;
            if (rd_pend)
                HRDATA <= rd_mux;
        end
    end

    assign GP_IO_OUT = gp;

    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    AST_BYTE_ONE_CLOCK: assert property (
        state == ST_BYTE |=> state == ST_IDLE)
        else $error("byte operation did not finish in one clock");
    AST_ADD_RESULT: assert property (
        state == ST_BYTE && op_q == OP_ADD_CARRY |=> dest[7:0] ==
        8'($past(dest[7:0]) + $past(src) + {7'h00, $past(flags[0])}))
        else $error("add with carry result wrong");
    AST_WORD_TWO_CLOCKS: assert property (
        state == ST_WORD_LO |=> state == ST_WORD_HI ##1 state == ST_IDLE)
        else $error("word operation did not take two clocks");
    AST_WORD_ADD_RESULT: assert property (
        state == ST_WORD_LO && op_q == OP_ADD_WORD |=> ##1 dest ==
        16'($past(dest, 2) + {8'h00, $past(src, 2) & WORD_IMM_MASK}))
        else $error("word add result wrong");
    AST_SUB_CARRY_RESULT: assert property (
        state == ST_BYTE && op_q == OP_SUB_CARRY |=> dest[7:0] ==
        8'($past(dest[7:0]) - $past(src) - {7'h00, $past(flags[0])}))
        else $error("subtract with carry result wrong");
    AST_SUB_IMM_BORROW: assert property (
        state == ST_BYTE && op_q == OP_SUB_IMM |=>
        flags[`FLG_C] == ($past(src) > $past(dest[7:0])))
        else $error("subtract immediate borrow wrong");
    AST_SUB_IMM_CARRY_ZERO: assert property (
        state == ST_BYTE && op_q == OP_SUB_IMM_CARRY |=>
        flags[`FLG_Z] == (dest[7:0] == 8'h00))
        else $error("subtract immediate with carry zero flag wrong");
    AST_WORD_SUB_BORROW: assert property (
        state == ST_WORD_HI && op_q == OP_SUB_WORD |=>
        flags[`FLG_C] == (dest[15] & ~$past(dest[15])))
        else $error("word subtract borrow wrong");
    AST_LOGIC_KEEPS_CARRY: assert property (
        state == ST_BYTE && op_logic |=> flags[`FLG_C] == $past(flags[0])
        && flags[`FLG_H] == $past(flags[5]) && !flags[`FLG_V])
        else $error("logic operation disturbed carry, half or overflow");
    AST_W1C_CLEARS: assert property (
        ioflag_wr |=> (io_flags & $past(HWDATA[7:0]) & ~$past(IO_EVENT))
        == 8'h00)
        else $error("written one did not clear the flag");
    AST_SET_BIT_CLEARS_ALL: assert property (
        io_hit_flags && HWDATA[`IOBIT_SET] |=>
        (io_flags & ~$past(IO_EVENT)) == 8'h00)
        else $error("bit set did not clear the set flags");
    AST_IO_RANGE: assert property (
        iobit_wr && !io_in_range |=> io_refused && $stable(gp))
        else $error("out of range bit operation was not refused");
    AST_SIGN_FLAG: assert property (
        state == ST_WORD_HI |=>
        flags[`FLG_S] == (flags[`FLG_N] ^ flags[`FLG_V]))
        else $error("sign flag is not N xor V");

    AST_ADD_HALF_CARRY: assert property (
        state == ST_BYTE && op_q == OP_ADD_REG |=> flags[`FLG_H] ==
        ({1'b0, $past(dest[3:0])} + {1'b0, $past(src[3:0])} > 5'h0F))
        else $error("add half carry wrong");

    AST_SUB_IMM_HALF_BORROW: assert property (
        state == ST_BYTE && op_q == OP_SUB_IMM |=>
        flags[`FLG_H] == ($past(src[3:0]) > $past(dest[3:0])))
        else $error("subtract immediate half borrow wrong");

    AST_WORD_SUB_RESULT: assert property (
        state == ST_WORD_LO && op_q == OP_SUB_WORD |=> ##1 dest ==
        16'($past(dest, 2) - {8'h00, $past(src, 2) & WORD_IMM_MASK}))
        else $error("word subtract result wrong");

    AST_OR_RESULT: assert property (
        state == ST_BYTE && op_q == OP_OR_REG |=>
        dest[7:0] == ($past(dest[7:0]) | $past(src)))
        else $error("or result wrong");

endmodule // byte_word_arith_logic_unit
`default_nettype wire

// ### sim/io_event_source.sv
`timescale 1ns/1ps
`default_nettype none
module io_event_source
(
    // clock
    input wire logic clk,
    // status events toward the unit
    output logic [7:0] event_out
);
    initial event_out = 8'h00;
    // one-cycle pulse so the flag is left for software to clear
    task automatic pulse(input logic [7:0] mask);
        begin
            event_out <= mask;
            @(posedge clk);
            event_out <= 8'h00;
        end
    endtask
endmodule // io_event_source
`default_nettype wire

// ### sim/byte_word_arith_logic_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "alu_defines.svh"
module byte_word_arith_logic_unit_test;
    import alu_pkg::*;
    logic clk, rst_n, hsel, hwrite;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, r;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp;
    wire logic [7:0] ev, gp;
    int n_mismatch = 0;
    int tests_run = 0;

    io_event_source src (.clk(clk), .event_out(ev));
    byte_word_arith_logic_unit #(.WORD_IMM_W(6)) dut (
        .CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .IO_EVENT(ev),
        .GP_IO_OUT(gp)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic close_out;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
            if (n_mismatch == 0 && tests_run > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    task automatic check(input string name, input logic [31:0] seen, exp);
        begin
            tests_run++;
            if (seen !== exp)
            begin
                n_mismatch++;
                $display("wrong value %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask

    // ready is settled at the falling edge, well clear of the sampling edge
    task automatic wait_ready;
        logic ok;
        int n;
        begin
            n = 0;
            do
            begin
                @(negedge clk);
                ok = hreadyout;
                r = hrdata;
                @(posedge clk);
                n++;
                if (n > 50)
                begin
                    n_mismatch++;
                    close_out();
                end
            end while (ok !== 1'b1);
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd);
        begin
            htrans <= `HTRANS_NONSEQ;
            haddr <= a;
            hwrite <= wr;
            wait_ready();
            htrans <= 2'h0;
            hwdata <= wd;
            wait_ready();
        end
    endtask

    task automatic run_op(input logic [3:0] op, input logic [15:0] d,
                          input logic [7:0] s, input logic [5:0] f,
                          input logic [15:0] rd, input logic [5:0] rf,
                          input logic b);
        begin
            bus(1'b1, `OFS_DEST, {16'h0000, d});
            bus(1'b1, `OFS_SRC, {24'h000000, s});
            bus(1'b1, `OFS_FLAGS, {26'h0, f});
            bus(1'b1, `OFS_CTRL, {28'h0, op});
            // word ops are still busy when this back-to-back read loads
            bus(1'b0, `OFS_CTRL, 32'h0);
            check("busy", {31'h0, r[`CTRL_BUSY]}, {31'h0, b});
            check("op", {28'h0, r[3:0]}, {28'h0, op});
            bus(1'b0, `OFS_DEST, 32'h0);
            check("dest", r, {16'h0000, rd});
            bus(1'b0, `OFS_FLAGS, 32'h0);
            check("flags", r, {26'h0, rf});
        end
    endtask

    task automatic test_arith;
        begin
            run_op(OP_ADD_REG, 'h0F, 'h01, 'h00, 'h10, 'h20, 0);
            run_op(OP_ADD_REG, 'h80, 'h80, 'h00, 'h00, 'h0B, 0);
            run_op(OP_ADD_CARRY, 'h7F, 'h00, 'h01, 'h80, 'h2C, 0);
            run_op(OP_SUB_REG, 'h00, 'h01, 'h00, 'hFF, 'h25, 0);
            run_op(OP_SUB_CARRY, 'h10, 'h0F, 'h01, 'h00, 'h22, 0);
            run_op(OP_SUB_IMM, 'h80, 'h01, 'h00, 'h7F, 'h28, 0);
            run_op(OP_SUB_IMM_CARRY, 'h05, 'h05, 'h01, 'hFF, 'h25, 0);
            $display("test arith done");
        end
    endtask

    task automatic test_logic;
        begin
            run_op(OP_AND_REG, 'hF0, 'h80, 'h29, 'h80, 'h25, 0);
            run_op(OP_AND_IMM, 'h0F, 'hF0, 'h29, 'h00, 'h23, 0);
            run_op(OP_OR_REG, 'h01, 'h80, 'h29, 'h81, 'h25, 0);
            run_op(OP_OR_IMM, 'h00, 'h00, 'h29, 'h00, 'h23, 0);
            $display("test logic done");
        end
    endtask

    task automatic test_word;
        begin
            run_op(OP_ADD_WORD, 'h7FFF, 'h01, 'h00, 'h8000, 'h0C, 1);
            run_op(OP_ADD_WORD, 'hFFFF, 'h01, 'h00, 'h0000, 'h03, 1);
            run_op(OP_SUB_WORD, 'h0000, 'h01, 'h00, 'hFFFF, 'h15, 1);
            run_op(OP_SUB_WORD, 'h8000, 'h01, 'h00, 'h7FFF, 'h18, 1);
            $display("test word done");
        end
    endtask

    task automatic test_refuse;
        begin
            bus(1'b1, `OFS_DEST, 32'h1234);
            bus(1'b1, `OFS_SRC, 32'h01);
            bus(1'b1, `OFS_CTRL, {28'h0, OP_ADD_WORD});
            // lands while the word op still runs, so it is dropped
            bus(1'b1, `OFS_DEST, 32'h5555);
            bus(1'b1, `OFS_CTRL, 32'h0C);
            bus(1'b0, `OFS_DEST, 32'h0);
            check("dest busy", r, 32'h1235);
            bus(1'b0, `OFS_CTRL, 32'h0);
            check("bad op", r, 32'h0A);
            $display("test refuse done");
        end
    endtask

    task automatic test_io;
        begin
            src.pulse(8'h05);
            bus(1'b0, `OFS_IOFLAG, 32'h0);
            check("ioflag", r, 32'h05);
            bus(1'b1, `OFS_IOFLAG, 32'h01);
            bus(1'b0, `OFS_IOFLAG, 32'h0);
            check("ioflag", r, 32'h04);
            src.pulse(8'h03);
            // clearing bit 1 writes back the other set flags as ones
            bus(1'b1, `OFS_IOBIT, 32'h0E01);
            bus(1'b0, `OFS_IOFLAG, 32'h0);
            check("ioflag", r, 32'h02);
            src.pulse(8'h30);
            // setting bit 0 writes every set flag back as a one
            bus(1'b1, `OFS_IOBIT, 32'h0E80);
            bus(1'b0, `OFS_IOFLAG, 32'h0);
            check("ioflag", r, 32'h00);
            bus(1'b1, `OFS_IOBIT, 32'h0F83);
            bus(1'b0, `OFS_IOGP, 32'h0);
            check("iogp", r, 32'h08);
            check("gp_out", {24'h0, gp}, 32'h08);
            bus(1'b1, `OFS_IOBIT, 32'h2081);
            bus(1'b0, `OFS_CTRL, 32'h0);
            check("refused", {31'h0, r[`CTRL_REFUSED]}, 32'h1);
            bus(1'b0, `OFS_IOGP, 32'h0);
            check("iogp", r, 32'h08);
            bus(1'b1, `OFS_IOBIT, 32'h1F81);
            bus(1'b0, `OFS_CTRL, 32'h0);
            check("refused", {31'h0, r[`CTRL_REFUSED]}, 32'h0);
            bus(1'b0, 32'h0000_0100, 32'h0);
            check("high addr", r, 32'h0);
            hsize <= 3'h0;
            bus(1'b0, `OFS_CTRL, 32'h0);
            hsize <= `HSIZE_WORD;
            check("narrow", r, 32'h0);
            bus(1'b0, 8'hFF, 32'h0);
            check("unmapped", r, 32'h0);
            check("hresp", {31'h0, hresp}, 32'h0);
            $display("test io done");
        end
    endtask

    initial
    begin
        rst_n = 1'b0;
        hsel = 1'b1;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = `HSIZE_WORD;
        haddr = 32'h0;
        hwdata = 32'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        test_arith();
        test_logic();
        test_word();
        test_refuse();
        test_io();
        close_out();
    end
endmodule // byte_word_arith_logic_unit_test
`default_nettype wire
